//--- wtsl_pkg.sv
// wtsl_pkg: constants for the watchdog with fuse-selected safety levels
// assumes a 40 MHz system clock and a 1 MHz oscillator tick derived from it
package wtsl_pkg;

   // ********************************************
   // clock and oscillator timing
   // ********************************************
   localparam int unsigned CLK_FREQ_HZ = 40_000_000;
   localparam int unsigned OSC_FREQ_HZ = 1_000_000;
   localparam int unsigned OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
   localparam int unsigned BASE_TICKS = 16_384;
   localparam int unsigned CNT_W = 21;
   localparam int unsigned CHG_WINDOW = 4;
   localparam logic [2:0] CHG_LOAD = 3'(CHG_WINDOW - 1);

   // ********************************************
   // register offsets (byte addresses)
   // ********************************************
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_RESTART = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;

   // ********************************************
   // control register fields
   // ********************************************
   localparam int unsigned CTL_PS_LSB = 0;
   localparam int unsigned CTL_EN_BIT = 3;
   localparam int unsigned CTL_CE_BIT = 4;
   localparam logic [2:0] CTL_PS_RST = 3'h0;

   // ********************************************
   // status register fields
   // ********************************************
   localparam int unsigned ST_FLAG_BIT = 0;
   localparam int unsigned ST_LVL_LSB = 1;
   localparam int unsigned ST_EN_BIT = 3;

   // ********************************************
   // bus answers
   // ********************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WTSL_LVL0,
      WTSL_LVL1,
      WTSL_LVL2
   } wtsl_level_t;

endpackage

//--- wtsl_osc_tick.sv
// wtsl_osc_tick: one-cycle enable at the watchdog oscillator rate
// assumes a single system clock with synchronous active-high reset
`timescale 1ns/1ps
module wtsl_osc_tick #(
   parameter int unsigned DIV = wtsl_pkg::OSC_DIV
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // tick out
   output logic tick_q
);

   logic [15:0] div_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q == 16'(DIV - 1)) begin
         div_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

endmodule

//--- wtsl_top.sv
// wtsl_top: watchdog with safety levels, AXI4-Lite register slave
// assumes fuse levels are static and por is a synchronous power-on pulse
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Contract
// R1 - counter advances on separate 1 MHz oscillator; the code uses a tick divided from the system clock instead
// R2 - restart clears the counter to zero
// R3 - counter cleared when disabled or reset
// R4 - timeout without restart resets the chip
// R5 - eight timeouts, 16384 doubling to 2097152
// R6 - fuses pick level and initial enable
// R7 - writing enable one always enables immediately
// R8 - control bits 7..5 read zero
// R9 - change-enable self-clears after four cycles
// R10 - enable zero accepted only with change-enable
// R11 - software disables by two-write timed sequence
// R12 - level 2 stays enabled, reads one
// R13 - level 2 ignores every disable attempt
// R14 - levels 1,2 change prescale only with change-enable
// R15 - level 0 changes prescale freely
// R16 - level 1 software uses two-write sequence
// R17 - level 2 sequence starts with enable one
// R18 - level 2 second write updates prescale only
// R19 - enable one enables, accepted zero disables
// R20 - timeout reset pulse one clock long
// R21 - flag set by timeout, cleared by por/zero
// R22 - expired window keeps configuration unchanged
// R23 - software keeps interrupts off during sequence
module wtsl_top #(
   parameter int unsigned BASE_TICKS = wtsl_pkg::BASE_TICKS,
   parameter int unsigned OSC_DIV = wtsl_pkg::OSC_DIV
) (
   // clock and resets
   input wire logic clk,
   input wire logic rst,
   input wire logic por,
   // fuses, high when programmed
   input wire logic legacy_compat_fuse,
   input wire logic always_on_fuse,
   // chip reset request
   output logic chip_reset_q,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ********************************************
   // helpers
   // ********************************************
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
      addr_is = (a[7:2] == off[7:2]);
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = addr_is(a, wtsl_pkg::OFF_CONTROL) || addr_is(a, wtsl_pkg::OFF_RESTART)
         || addr_is(a, wtsl_pkg::OFF_STATUS);
   endfunction

   // ********************************************
   // state
   // ********************************************
   logic aw_full_q, w_full_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic w_lane0_q;
   logic wr_go;
   logic ctrl_wr, restart_wr, status_wr;
   logic fuse_done_q;
   wtsl_pkg::wtsl_level_t level_q;
   logic enable_q, en_eff;
   logic ce_q;
   logic [2:0] ce_cnt_q;
   logic [2:0] prescale_q;
   logic flag_q;
   logic [wtsl_pkg::CNT_W-1:0] count_q;
   logic [wtsl_pkg::CNT_W-1:0] limit;
   logic osc_tick;
   logic timeout;
   logic [7:0] ctrl_rd;

   // ********************************************
   // oscillator tick
   // ********************************************
   wtsl_osc_tick #(.DIV(OSC_DIV)) u_tick (
      .clk(clk),
      .rst(rst),
      .tick_q(osc_tick)
   );

   // ********************************************
   // write channels
   // ********************************************
   assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
   assign ctrl_wr = wr_go && w_lane0_q && addr_is(aw_addr_q, wtsl_pkg::OFF_CONTROL);
   assign restart_wr = wr_go && addr_is(aw_addr_q, wtsl_pkg::OFF_RESTART);
   assign status_wr = wr_go && w_lane0_q && addr_is(aw_addr_q, wtsl_pkg::OFF_STATUS);

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_full_q <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_q <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_full_q <= 1'b0;
      end else if (!aw_full_q) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         w_full_q <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_lane0_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_q <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data_q <= s_axi_wdata;
         w_lane0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_full_q <= 1'b0;
      end else if (!w_full_q) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= wtsl_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_known(aw_addr_q) ? wtsl_pkg::RESP_OKAY : wtsl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ********************************************
   // fuse capture and safety level
   // ********************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         fuse_done_q <= 1'b0;
         level_q <= wtsl_pkg::WTSL_LVL1;
      end else if (!fuse_done_q) begin
         fuse_done_q <= 1'b1;
         if (always_on_fuse) begin
            level_q <= wtsl_pkg::WTSL_LVL2; // [R6]
         end else if (legacy_compat_fuse) begin
            level_q <= wtsl_pkg::WTSL_LVL0; // [R6]
         end else begin
            level_q <= wtsl_pkg::WTSL_LVL1; // [R6]
         end
      end
   end

   // level 2 forces enabled and reads one
   assign en_eff = enable_q || (level_q == wtsl_pkg::WTSL_LVL2); // [R12]

   // ********************************************
   // change-enable window
   // ********************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         ce_q <= 1'b0;
         ce_cnt_q <= 3'h0;
      end else if (ctrl_wr && w_data_q[wtsl_pkg::CTL_CE_BIT]) begin
         ce_q <= 1'b1;
         ce_cnt_q <= wtsl_pkg::CHG_LOAD; // [R9]
      end else if (ctrl_wr) begin
         ce_q <= 1'b0;
      end else if (ce_q) begin
         if (ce_cnt_q == 3'h0) begin
            ce_q <= 1'b0; // [R9] [R22]
         end else begin
            ce_cnt_q <= ce_cnt_q - 3'h1;
         end
      end
   end

   // ********************************************
   // enable and prescale
   // ********************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_q <= 1'b0;
      end else if (ctrl_wr) begin
         if (w_data_q[wtsl_pkg::CTL_EN_BIT]) begin
            enable_q <= 1'b1; // [R7] [R19]
         end else if (ce_q && level_q != wtsl_pkg::WTSL_LVL2) begin
            enable_q <= 1'b0; // [R10] [R11] [R19] [R13]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prescale_q <= wtsl_pkg::CTL_PS_RST;
      end else if (ctrl_wr) begin
         if (level_q == wtsl_pkg::WTSL_LVL0 || ce_q) begin
            prescale_q <= w_data_q[wtsl_pkg::CTL_PS_LSB +: 3]; // [R14] [R15] [R16] [R18]
         end
      end
   end

   // ********************************************
   // counter and timeout
   // ********************************************
   assign limit = wtsl_pkg::CNT_W'(BASE_TICKS) << prescale_q; // [R5]
   assign timeout = en_eff && osc_tick && (count_q == limit - 1'b1);

   always_ff @(posedge clk) begin
      if (rst || restart_wr || !en_eff || timeout) begin
         count_q <= '0; // [R2] [R3]
      end else if (osc_tick) begin
         count_q <= count_q + 1'b1; // [R1]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chip_reset_q <= 1'b0;
      end else begin
         chip_reset_q <= timeout; // [R4] [R20]
      end
   end

   // survives chip reset, cleared by power-on or a zero write
   always_ff @(posedge clk) begin
      if (por) begin
         flag_q <= 1'b0;
      end else if (timeout) begin
         flag_q <= 1'b1; // [R21]
      end else if (status_wr && !w_data_q[wtsl_pkg::ST_FLAG_BIT]) begin
         flag_q <= 1'b0; // [R21]
      end
   end

   // ********************************************
   // read channel
   // ********************************************
   assign ctrl_rd = {3'h0, ce_q, en_eff, prescale_q}; // [R8]

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= wtsl_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= wtsl_pkg::RESP_OKAY;
         if (addr_is(s_axi_araddr, wtsl_pkg::OFF_CONTROL)) begin
            s_axi_rdata <= {24'h00_0000, ctrl_rd};
         end else if (addr_is(s_axi_araddr, wtsl_pkg::OFF_STATUS)) begin
            s_axi_rdata <= {28'h000_0000, en_eff, 2'(level_q), flag_q};
         end else if (addr_is(s_axi_araddr, wtsl_pkg::OFF_RESTART)) begin
            s_axi_rdata <= 32'h0000_0000;
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= wtsl_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ********************************************
   // assertions
   // ********************************************
   ce_window_a: assert property (@(posedge clk) disable iff (rst) // [R9]
      (ctrl_wr && w_data_q[wtsl_pkg::CTL_CE_BIT]) ##1 (!ctrl_wr) [*4] |=> !ce_q)
      else $error("change enable not cleared after four cycles");

   ce_hold_a: assert property (@(posedge clk) disable iff (rst) // [R9]
      (ctrl_wr && w_data_q[wtsl_pkg::CTL_CE_BIT]) ##1 (!ctrl_wr) [*3] |-> ce_q)
      else $error("change enable dropped early");

   en_on_a: assert property (@(posedge clk) disable iff (rst) // [R7]
      ctrl_wr && w_data_q[wtsl_pkg::CTL_EN_BIT] |=> en_eff)
      else $error("enable write did not enable");

   dis_guard_a: assert property (@(posedge clk) disable iff (rst) // [R10]
      ctrl_wr && !ce_q && enable_q |=> enable_q)
      else $error("disabled without change enable");

   dis_ok_a: assert property (@(posedge clk) disable iff (rst) // [R19]
      ctrl_wr && ce_q && !w_data_q[wtsl_pkg::CTL_EN_BIT]
      && level_q != wtsl_pkg::WTSL_LVL2 |=> !en_eff)
      else $error("accepted disable did not disable");

   lvl2_on_a: assert property (@(posedge clk) disable iff (rst) // [R12]
      s_axi_rvalid && level_q == wtsl_pkg::WTSL_LVL2 && $past(s_axi_arvalid && s_axi_arready
      && addr_is(s_axi_araddr, wtsl_pkg::OFF_CONTROL)) |-> s_axi_rdata[3])
      else $error("level 2 not enabled");

   lvl2_dis_a: assert property (@(posedge clk) disable iff (rst) // [R13]
      ctrl_wr && level_q == wtsl_pkg::WTSL_LVL2 |=> en_eff [*2])
      else $error("level 2 disabled");

   ps_lock_a: assert property (@(posedge clk) disable iff (rst) // [R14]
      ctrl_wr && !ce_q && level_q != wtsl_pkg::WTSL_LVL0 |=> $stable(prescale_q))
      else $error("prescale changed without change enable");

   ps_free_a: assert property (@(posedge clk) disable iff (rst) // [R15]
      ctrl_wr && level_q == wtsl_pkg::WTSL_LVL0 |=> prescale_q == $past(w_data_q[2:0]))
      else $error("level 0 prescale write lost");

   restart_a: assert property (@(posedge clk) disable iff (rst) // [R2]
      restart_wr |=> count_q == '0)
      else $error("restart did not clear counter");

   off_clear_a: assert property (@(posedge clk) disable iff (rst) // [R3]
      !en_eff ##1 !en_eff |-> count_q == '0)
      else $error("counter runs while disabled");

   timeout_a: assert property (@(posedge clk) disable iff (rst) // [R4]
      en_eff && osc_tick && count_q == limit - 1'b1 |=> chip_reset_q ##1 !chip_reset_q)
      else $error("timeout did not give a one-cycle reset");

   flag_set_a: assert property (@(posedge clk) disable iff (por) // [R21]
      chip_reset_q |-> flag_q)
      else $error("reset flag not set by timeout");

   ctrl_res_a: assert property (@(posedge clk) disable iff (rst) // [R8]
      s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready
      && addr_is(s_axi_araddr, wtsl_pkg::OFF_CONTROL)) |-> s_axi_rdata[31:5] == '0)
      else $error("reserved control bits not zero");

   timeout_c: cover property (@(posedge clk) disable iff (rst) chip_reset_q);
   disable_c: cover property (@(posedge clk) disable iff (rst)
      ctrl_wr && ce_q && !w_data_q[wtsl_pkg::CTL_EN_BIT] ##1 !en_eff);
   ps_seq_c: cover property (@(posedge clk) disable iff (rst)
      ctrl_wr && ce_q && level_q == wtsl_pkg::WTSL_LVL1);
   expire_c: cover property (@(posedge clk) disable iff (rst) $fell(ce_q) && !ctrl_wr);

endmodule

//--- tb.sv
// tb: self-checking bench for the watchdog with fuse-selected safety levels
// assumes wtsl_pkg and wtsl_top are compiled first; shortened counts via parameters
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
   // ********************************************
   // signals
   // ********************************************
   localparam int BT = 16;
   localparam int OD = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic por = 1'b1;
   logic lc_fuse = 1'b0;
   logic ao_fuse = 1'b0;
   logic chip_reset_q;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic [31:0] rdata;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] seed = 32'hED51C55E;
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int pulses = 0;

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (chip_reset_q === 1'b1) pulses <= pulses + 1;
   end

   wtsl_top #(.BASE_TICKS(BT), .OSC_DIV(OD)) DUT (.clk(clk), .rst(rst), .por(por),
      .legacy_compat_fuse(lc_fuse), .always_on_fuse(ao_fuse), .chip_reset_q(chip_reset_q),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // ********************************************
   // helpers
   // ********************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [31:0] st_exp(int i);
      if (i % 2 == 1) return 32'h0000000C;
      return (i >= 2) ? 32'h00000000 : 32'h00000002;
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                     output int t);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 400);
      if (n >= 400) errors++;
      r = bresp;
      t = cyc;
      bready <= 1'b0;
   endtask

   task automatic ctl(input logic [31:0] d, output int t);
      logic [1:0] r;
      wr(8'h00, d, r, t);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 400);
      if (n >= 400) errors++;
      rready <= 1'b0;
      `CHK(rdata, e)
      `CHK(rresp, er)
   endtask

   task automatic do_reset(input logic lc, input logic ao);
      @(posedge clk);
      rst <= 1'b1;
      lc_fuse <= lc;
      ao_fuse <= ao;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // timed pair; outcome depends on whether the second write landed in the window
   task automatic seq(input logic [31:0] d2, input logic [31:0] e_ok, input logic [31:0] e_late);
      int t1;
      int t2;
      ctl(32'h00000018, t1);
      ctl(d2, t2);
      rdchk(8'h00, (t2 - t1 <= 4) ? e_ok : e_late, 2'h0);
   endtask

   // ********************************************
   // scenarios
   // ********************************************
   initial begin
      int t;
      int n;
      int el;
      int ex;
      int p0;
      logic [1:0] r;
      logic [31:0] x;
      for (int i = 0; i < 4; i++) begin
         do_reset(i >= 2, i % 2 == 1);
         rdchk(8'h08, st_exp(i), 2'h0);
      end
      rdchk(8'h00, 32'h00000008, 2'h0);
      ctl(32'h00000000, t);
      rdchk(8'h00, 32'h00000008, 2'h0);
      seq(32'h00000005, 32'h0000000D, 32'h00000008);
      do_reset(1'b0, 1'b0);
      x = rnd();
      ctl({x[31:8], 8'hE9}, t);
      rdchk(8'h00, 32'h00000008, 2'h0);
      ctl(32'h00000000, t);
      rdchk(8'h00, 32'h00000008, 2'h0);
      ctl(32'h00000018, t);
      repeat (10) @(posedge clk);
      rdchk(8'h00, 32'h00000008, 2'h0);
      ctl(32'h00000007, t);
      rdchk(8'h00, 32'h00000008, 2'h0);
      seq(32'h00000006, 32'h00000006, 32'h00000008);
      do_reset(1'b1, 1'b0);
      ctl(32'h0000000B, t);
      rdchk(8'h00, 32'h0000000B, 2'h0);
      ctl(32'h00000008, t);
      rdchk(8'h00, 32'h00000008, 2'h0);
      wstrb <= 4'hE;
      ctl(32'h0000000F, t);
      wstrb <= 4'hF;
      rdchk(8'h00, 32'h00000008, 2'h0);
      p0 = pulses;
      repeat (24) wr(8'h04, rnd(), r, t);
      `CHK(pulses, p0)
      rdchk(8'h04, 32'h0, 2'h0);
      wr(8'h0C, rnd(), r, t);
      `CHK(r, 2'h2)
      rdchk(8'h0C, 32'h0, 2'h2);
      for (int p = 0; p < 8; p++) begin
         do_reset(1'b1, 1'b0);
         ctl(32'h00000008 | 32'(p), t);
         n = 0;
         while (chip_reset_q !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
         end
         el = cyc - t;
         ex = ((BT << p) - 1) * OD;
         `CHK(el > ex && el <= ex + OD, 1'b1)
         @(posedge clk);
         `CHK(chip_reset_q, 1'b0)
         rdchk(8'h08, 32'h00000009, 2'h0);
         do_reset(1'b1, 1'b0);
         rdchk(8'h08, 32'h00000001, 2'h0);
         if (p % 2 == 1) begin
            wr(8'h08, 32'h0, r, t);
         end else begin
            @(posedge clk);
            por <= 1'b1;
            @(posedge clk);
            por <= 1'b0;
         end
         rdchk(8'h08, 32'h00000000, 2'h0);
      end
      give_verdict();
   end

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      give_verdict();
   end
endmodule
